// ### ecl_top.sv
// Purpose: Event counter with compare match, compare list loading and status
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   Commands are write-one pulses in the command register
//
// Behaviour
// RULE_01: Count increments on each rising edge of the selected external input.
// RULE_02: Software may select the external clock pin as counted signal.
// RULE_03: Count reaching compare value is a match and triggers match handling.
// RULE_04: With loading on, each match loads next compare value from list.
// RULE_05: After last entry, wrap to first or hold last, per configuration.
// RULE_06: Input filter is bypassed or needs 1 us steady level.
// RULE_07: A match raises a compare-match event pulse.
// RULE_08: An overrun raises an overrun event pulse.
// RULE_09: An operation error halting counting raises an error event pulse.
// RULE_10: Start and stop commands; stop works any time after start.
// RULE_11: Status and count reads never disturb counting.
// RULE_12: Running flag set by start, cleared by stop or error.
// RULE_13: Match flag set on match after start, cleared by status reset.
// RULE_14: Overrun flag set on match while match flag set, sticky.
// RULE_15: Overrun does not stop counting.
// RULE_16: A match while overrun is set is an error and halts counting.
// RULE_17: Current count is readable by software.
// RULE_18: Counter reset command restores the power-up state.
// RULE_19: Status reset clears match and overrun flags.
// RULE_20: Count width, list depth fixed; counter reset rewinds list pointer.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "ecl_map.svh"
module ecl_top
  import ecl_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cnt_in_i,
  input  wire logic                   ext_clk_i,
  input  wire logic [`ECL_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [`ECL_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  output logic                        evt_match_o,
  output logic                        evt_ovr_o,
  output logic                        evt_err_o
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] ecl_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction : ecl_merge

  function automatic logic ecl_mapped(input logic [`ECL_ADDR_W-1:0] a);
    return (a == `ECL_OFS_CTRL) || (a == `ECL_OFS_CMD) || (a == `ECL_OFS_STAT) ||
           (a == `ECL_OFS_COUNT) || (a == `ECL_OFS_CMP) || (a == `ECL_OFS_LDATA) ||
           (a == `ECL_OFS_LLEN);
  endfunction : ecl_mapped

  // Last valid list entry; a length of 0 acts as 1
  function automatic logic ecl_is_last(input ecl_ptr_t p, input ecl_len_t len);
    return (len <= `ECL_LEN_W'(1)) || ({1'b0, p} == len - `ECL_LEN_W'(1));
  endfunction : ecl_is_last

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  ecl_flt_if                 fi ();
  logic [`ECL_CTRL_W-1:0]    ctrl;
  ecl_len_t                  llen;
  ecl_cnt_t                  count;
  ecl_cnt_t                  cmp;
  ecl_cnt_t                  list [`ECL_LIST_D];
  ecl_ptr_t                  rptr;
  ecl_ptr_t                  wptr;
  logic                      load_done;
  logic                      sts_match;
  logic                      sts_ovr;
  ecl_run_t                  state;
  logic [`ECL_ADDR_W-1:0]    aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      aw_held;
  logic                      w_held;

  ecl_filter u_filter (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cnt_in_i  (cnt_in_i),
    .ext_clk_i (ext_clk_i),
    .fi        (fi.flt)
  );

  assign fi.src_clk = ctrl[`ECL_CTRL_SRC];
  assign fi.flt_on  = ctrl[`ECL_CTRL_FLT];

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire        wr_go     = aw_held && w_held;
  wire [31:0] wr_word   = ecl_merge(32'h0, w_data, w_strb);
  wire        wr_ctrl   = wr_go && (aw_addr == `ECL_OFS_CTRL);
  wire        wr_cmd    = wr_go && (aw_addr == `ECL_OFS_CMD);
  wire        wr_cmp    = wr_go && (aw_addr == `ECL_OFS_CMP);
  wire        wr_ldata  = wr_go && (aw_addr == `ECL_OFS_LDATA);
  wire        wr_llen   = wr_go && (aw_addr == `ECL_OFS_LLEN);
  wire        cmd_start = wr_cmd && wr_word[`ECL_CMD_START];
  wire        cmd_stop  = wr_cmd && wr_word[`ECL_CMD_STOP];
  wire        cmd_crst  = wr_cmd && wr_word[`ECL_CMD_CRST];
  wire        cmd_srst  = wr_cmd && wr_word[`ECL_CMD_SRST];
  wire        running   = state == ECL_RUN;
  wire        halted    = state == ECL_FAULT;
  wire        pulse     = fi.pulse;
  wire [31:0] count_inc = count + 32'h1;
  wire        match_ev  = running && pulse && (count_inc == cmp);
  wire        ovr_ev    = match_ev && sts_match;
  wire        err_ev    = match_ev && sts_ovr;
  wire        load_on   = ctrl[`ECL_CTRL_LOAD];
  wire        load_step = match_ev && load_on && !load_done;
  wire        at_last   = ecl_is_last(rptr, llen);
  wire        first_end = ecl_is_last('0, llen);
  wire [31:0] stat_word = {28'h0, halted, sts_ovr, sts_match, running};
  wire [31:0] rd_word   =
    (s_axi_araddr_i == `ECL_OFS_CTRL)  ? {28'h0, ctrl} :
    (s_axi_araddr_i == `ECL_OFS_STAT)  ? stat_word :
    (s_axi_araddr_i == `ECL_OFS_COUNT) ? count :
    (s_axi_araddr_i == `ECL_OFS_CMP)   ? cmp :
    (s_axi_araddr_i == `ECL_OFS_LLEN)  ? {28'h0, llen} : 32'h0;

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_addr         <= '0;
      w_data          <= 32'h0;
      w_strb          <= 4'h0;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `ECL_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr         <= s_axi_awaddr_i;
        aw_held         <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        w_held         <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= ecl_mapped(aw_addr) ? `ECL_RESP_OK : `ECL_RESP_DEC;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel, independent of counting
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= `ECL_RESP_OK;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word; // RULE_11 RULE_17
        s_axi_rresp_o   <= ecl_mapped(s_axi_araddr_i) ? `ECL_RESP_OK : `ECL_RESP_DEC;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration and compare list
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `ECL_CTRL_RST;
      llen <= `ECL_LLEN_RST;
      wptr <= '0;
      for (int i = 0; i < `ECL_LIST_D; i++) list[i] <= '0;
    end else if (cmd_crst) begin
      ctrl <= `ECL_CTRL_RST; // RULE_18
      llen <= `ECL_LLEN_RST;
      wptr <= '0; // RULE_20
      for (int i = 0; i < `ECL_LIST_D; i++) list[i] <= '0;
    end else begin
      if (wr_ctrl) ctrl <= wr_word[`ECL_CTRL_W-1:0];
      if (wr_llen) llen <= wr_word[`ECL_LEN_W-1:0];
      if (wr_ldata) begin
        list[wptr] <= ecl_merge(list[wptr], w_data, w_strb);
        wptr       <= wptr + `ECL_PTR_W'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // Run state
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ECL_IDLE;
    end else if (cmd_crst || cmd_stop) begin
      state <= ECL_IDLE; // RULE_10 RULE_12 RULE_18
    end else begin
      case (state)
        ECL_IDLE, ECL_FAULT: begin
          if (cmd_start) state <= ECL_RUN; // RULE_10 RULE_12
        end
        ECL_RUN: begin
          if (err_ev) state <= ECL_FAULT; // RULE_16
        end
        default: state <= ECL_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Count and compare loading
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (cmd_crst) begin
      count <= '0; // RULE_18
    end else if (running && pulse) begin
      count <= count_inc; // RULE_01 RULE_15
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp       <= '0;
      rptr      <= '0;
      load_done <= 1'b0;
    end else if (cmd_crst) begin
      cmp       <= '0;
      rptr      <= '0; // RULE_20
      load_done <= 1'b0;
    end else if (cmd_start && load_on) begin
      cmp       <= list[0]; // RULE_04
      rptr      <= first_end ? '0 : `ECL_PTR_W'(1);
      load_done <= first_end && !ctrl[`ECL_CTRL_WRAP];
    end else if (load_step) begin
      cmp <= list[rptr]; // RULE_04
      if (at_last) begin
        rptr      <= '0; // RULE_05
        load_done <= !ctrl[`ECL_CTRL_WRAP]; // RULE_05
      end else begin
        rptr <= rptr + `ECL_PTR_W'(1);
      end
    end else if (wr_cmp) begin
      cmp <= ecl_merge(cmp, w_data, w_strb);
    end
  end

  // ------------------------------------------------------------------
  // Sticky status flags, set wins over status reset, counter reset wins over set
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sts_match <= 1'b0;
      sts_ovr   <= 1'b0;
    end else if (cmd_crst) begin
      sts_match <= 1'b0;
      sts_ovr   <= 1'b0;
    end else begin
      sts_match <= match_ev || (sts_match && !cmd_srst); // RULE_03 RULE_13 RULE_19
      sts_ovr   <= ovr_ev || (sts_ovr && !cmd_srst); // RULE_14 RULE_19
    end
  end

  // ------------------------------------------------------------------
  // Event pulses
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_match_o <= 1'b0;
      evt_ovr_o   <= 1'b0;
      evt_err_o   <= 1'b0;
    end else begin
      evt_match_o <= match_ev; // RULE_07
      evt_ovr_o   <= ovr_ev; // RULE_08
      evt_err_o   <= err_ev && !cmd_crst && !cmd_stop; // RULE_09
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet;
    !wr_cmd;
  endsequence
  sequence s_second_match;
    match_ev && sts_match and s_quiet;
  endsequence
  sequence s_third_match;
    match_ev && sts_ovr and s_quiet;
  endsequence

  a_count_step : assert property (running && pulse and s_quiet |=> count == $past(count_inc)) // RULE_01
    else $error("count did not advance on an input pulse");
  a_match_flag : assert property (match_ev and s_quiet |=> sts_match ##0 evt_match_o) // RULE_13
    else $error("match did not set flag and event");
  a_ovr_flag : assert property (s_second_match |=> sts_ovr && evt_ovr_o) // RULE_14
    else $error("second match did not set overrun");
  a_ovr_runs : assert property (s_second_match and !sts_ovr |=> running) // RULE_15
    else $error("overrun stopped the counter");
  a_err_halts : assert property (s_third_match |=> halted && evt_err_o ##1 !running) // RULE_16
    else $error("unserviced match did not halt counting");
  a_stop_cmd : assert property (cmd_stop |=> !running ##1 $stable(count)) // RULE_10
    else $error("stop command not honoured");
  a_status_clear : assert property (cmd_srst && !match_ev && !cmd_crst |=> !sts_match && !sts_ovr) // RULE_19
    else $error("status reset did not clear flags");
  a_load_next : assert property (load_step and s_quiet |=> cmp == $past(list[rptr])) // RULE_04
    else $error("compare value not loaded from list");
  a_load_hold : assert property (load_step && at_last && !ctrl[`ECL_CTRL_WRAP] and s_quiet
    |=> load_done && rptr == '0) // RULE_05
    else $error("list end did not stop loading");
  a_counter_rst : assert property (cmd_crst |=> count == '0 && state == ECL_IDLE
    && !sts_match && rptr == '0) // RULE_18
    else $error("counter reset incomplete");
endmodule : ecl_top

// ### ecl_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 20 MHz clk_i, AXI4-Lite word registers
// Notes:   Definitions only
`ifndef ECL_MAP_SVH
`define ECL_MAP_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define ECL_ADDR_W      8
`define ECL_OFS_CTRL    8'h00
`define ECL_OFS_CMD     8'h04
`define ECL_OFS_STAT    8'h08
`define ECL_OFS_COUNT   8'h0C
`define ECL_OFS_CMP     8'h10
`define ECL_OFS_LDATA   8'h14
`define ECL_OFS_LLEN    8'h18

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ECL_CTRL_W      4
`define ECL_CTRL_SRC    0
`define ECL_CTRL_FLT    1
`define ECL_CTRL_LOAD   2
`define ECL_CTRL_WRAP   3
`define ECL_CMD_START   0
`define ECL_CMD_STOP    1
`define ECL_CMD_CRST    2
`define ECL_CMD_SRST    3

// ------------------------------------------------------------------
// Sizes and reset values
// ------------------------------------------------------------------
`define ECL_CNT_W       32
`define ECL_LIST_D      8
`define ECL_PTR_W       3
`define ECL_LEN_W       4
`define ECL_CTRL_RST    4'h0
`define ECL_LLEN_RST    4'h1
`define ECL_RESP_OK     2'h0
`define ECL_RESP_DEC    2'h3

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define ECL_CLK_NS      50
`define ECL_FLT_NS      1000
`define ECL_FLT_CYC     ((`ECL_FLT_NS + `ECL_CLK_NS - 1) / `ECL_CLK_NS)
`define ECL_FLT_CW      5

`endif

// ### ecl_pkg.sv
// Purpose: Shared types of the event counter
// Assumes: ecl_map.svh holds all numbers
// Notes:   Types only
package ecl_pkg;
  `include "ecl_map.svh"

  typedef logic [`ECL_CNT_W-1:0] ecl_cnt_t;
  typedef logic [`ECL_PTR_W-1:0] ecl_ptr_t;
  typedef logic [`ECL_LEN_W-1:0] ecl_len_t;
  typedef enum logic [1:0] {ECL_IDLE, ECL_RUN, ECL_FAULT} ecl_run_t;
endpackage : ecl_pkg

// ### ecl_flt_if.sv
// Purpose: Carrier between counter core and input filter
// Assumes: Single clock domain
// Notes:   No clocking block
`timescale 1ns/10ps
interface ecl_flt_if;
  logic src_clk;
  logic flt_on;
  logic pulse;

  modport ctl (output src_clk, output flt_on, input pulse);
  modport flt (input src_clk, input flt_on, output pulse);
endinterface : ecl_flt_if

// ### ecl_filter.sv
// Purpose: Synchronise, select and filter the counted input
// Assumes: Pins are asynchronous to clk_i
// Notes:   Emits a one-cycle pulse per filtered rising edge
`timescale 1ns/10ps
`include "ecl_map.svh"
module ecl_filter
  import ecl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cnt_in_i,
  input  wire logic ext_clk_i,
  ecl_flt_if.flt    fi
);
  logic [2:0]            s_in;
  logic [2:0]            s_ck;
  logic                  in_lvl;
  logic                  ck_lvl;
  logic                  flt_lvl;
  logic                  flt_prev;
  logic [`ECL_FLT_CW-1:0] flt_cnt;
  logic                  pulse;
  wire                   sel_lvl = fi.src_clk ? ck_lvl : in_lvl;
  wire                   differ  = sel_lvl != flt_lvl;
  wire                   settled = flt_cnt == `ECL_FLT_CW'(`ECL_FLT_CYC - 1);

  assign fi.pulse = pulse;

  // ------------------------------------------------------------------
  // Three-stage synchronisers, level taken once stages two and three agree
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_in   <= 3'h0;
      s_ck   <= 3'h0;
      in_lvl <= 1'b0;
      ck_lvl <= 1'b0;
    end else begin
      s_in <= {s_in[1:0], cnt_in_i};
      s_ck <= {s_ck[1:0], ext_clk_i};
      if (s_in[1] == s_in[2]) in_lvl <= s_in[2]; // RULE_01
      if (s_ck[1] == s_ck[2]) ck_lvl <= s_ck[2]; // RULE_02
    end
  end

  // ------------------------------------------------------------------
  // Bypass or hold-off filter, then edge pulse
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flt_lvl <= 1'b0;
      flt_cnt <= '0;
    end else if (!fi.flt_on || (differ && settled)) begin
      flt_lvl <= sel_lvl; // RULE_06
      flt_cnt <= '0;
    end else if (differ) begin
      flt_cnt <= flt_cnt + `ECL_FLT_CW'(1); // RULE_06
    end else begin
      flt_cnt <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flt_prev <= 1'b0;
      pulse    <= 1'b0;
    end else begin
      flt_prev <= flt_lvl;
      pulse    <= flt_lvl && !flt_prev;
    end
  end

  a_flt_hold : assert property (@(posedge clk_i) disable iff (rst_i)
    fi.flt_on && $rose(flt_lvl) |-> $past(sel_lvl, `ECL_FLT_CYC)) // RULE_06
    else $error("filtered level rose before the hold-off time");
endmodule : ecl_filter

// ### ecl_pulse_src.sv
// Purpose: Far-side pulse source for the counted input and external clock pins
// Assumes: Driven pins idle low between pulses
// Notes:   Changes pins just after a rising clock edge
`timescale 1ns/10ps
module ecl_pulse_src (
  input  wire logic clk_i,
  output logic      cnt_o,
  output logic      ext_o
);
  initial begin
    cnt_o = 1'b0;
    ext_o = 1'b0;
  end

  // One rising edge per pulse on the chosen pin
  task automatic burst(input int n, input bit sel, input int hi, input int lo);
    repeat (n) begin
      if (sel) ext_o <= 1'b1;
      else cnt_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      cnt_o <= 1'b0;
      ext_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask : burst
endmodule : ecl_pulse_src

// ### event_counter_compare_load_tb_top.sv
// Purpose: Self-checking bench of the event counter
// Assumes: 20 MHz clock, AXI4-Lite master tasks, integer model
// Notes:   Model compared after every burst of pulses
`timescale 1ns/10ps
`include "ecl_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module event_counter_compare_load_tb_top;
  import ecl_pkg::*;
  logic        clk_i, rst_i, cnt_in, ext_clk, awv, awr, wv, wrd, bv, br;
  logic        arv, arr, rv, rr, em, eo, ee;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdd, rdat;
  logic [1:0]  bres, rres, resp;
  int          fails, n_compared, n_m, n_o, n_e, e_m, e_o, e_e, m_cnt, m_cmp, m_ptr, m_len;
  bit          m_run, m_mat, m_ovr, m_err, m_load, m_wrap, m_done;
  int          lst[$];

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ecl_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cnt_in_i(cnt_in), .ext_clk_i(ext_clk),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(bres), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdd), .s_axi_rresp_o(rres), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .evt_match_o(em), .evt_ovr_o(eo), .evt_err_o(ee));
  ecl_pulse_src i_src (.clk_i(clk_i), .cnt_o(cnt_in), .ext_o(ext_clk));

  always @(posedge clk_i) begin
    if (em === 1'b1) n_m++;
    if (eo === 1'b1) n_o++;
    if (ee === 1'b1) n_e++;
  end

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------------
  // Bus master
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; k = 0;
    do begin
      @(posedge clk_i); k++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && k < 100);
    br <= 1'b0; resp = bres;
    if (bv !== 1'b1) begin fails++; print_verdict(); end
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int k;
    ara <= a; arv <= 1'b1; rr <= 1'b1; k = 0;
    do begin
      @(posedge clk_i); k++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && k < 100);
    rr <= 1'b0; rdat = rdd; resp = rres;
    if (rv !== 1'b1) begin fails++; print_verdict(); end
    @(posedge clk_i);
  endtask : rd

  task automatic cmd(input int b);
    wr(`ECL_OFS_CMD, 32'(1 << b));
  endtask : cmd

  // ------------------------------------------------------------------
  // Model
  // ------------------------------------------------------------------
  task automatic mreset();
    m_cnt = 0; m_cmp = 0; m_run = 0; m_mat = 0; m_ovr = 0; m_err = 0;
    m_load = 0; m_wrap = 0; m_done = 0; m_ptr = 0; m_len = 1; lst.delete();
  endtask : mreset

  task automatic mstart();
    m_run = 1; m_err = 0; m_done = 0;
    if (m_load) begin m_cmp = lst[0]; m_ptr = 1; end
  endtask : mstart

  task automatic mp(input int n);
    repeat (n) if (m_run) begin
      m_cnt++;
      if (m_cnt == m_cmp) begin
        e_m++;
        if (m_mat) e_o++;
        if (m_ovr) begin m_err = 1; m_run = 0; e_e++; end
        if (m_mat) m_ovr = 1;
        m_mat = 1;
        if (m_load && !m_done) begin
          m_cmp = lst[m_ptr]; m_ptr++;
          if (m_ptr >= m_len) begin if (m_wrap) m_ptr = 0; else m_done = 1; end
        end
      end
    end
  endtask : mp

  task automatic pb(input int n, input bit sel, input int hi);
    i_src.burst(n, sel, hi, hi);
    mp(n);
    repeat (40) @(posedge clk_i);
  endtask : pb

  task automatic chk_all();
    rd(`ECL_OFS_STAT);
    `CHK(rdat[3:0], {m_err, m_ovr, m_mat, m_run})
    rd(`ECL_OFS_COUNT);
    `CHK(rdat, 32'(m_cnt))
    `CHK(n_m, e_m)
    `CHK(n_o, e_o)
    `CHK(n_e, e_e)
  endtask : chk_all

  initial begin
    rst_i = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; mreset();
    void'($urandom(32'h2A84BDEA));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`ECL_OFS_CTRL);
    `CHK(rdat, 32'h0)
    rd(`ECL_OFS_LLEN);
    `CHK(rdat, 32'h1)
    chk_all();
    rd(8'h1C);
    `CHK(resp, `ECL_RESP_DEC)
    wr(8'h1C, 32'hFFFF_FFFF);
    `CHK(resp, `ECL_RESP_DEC)
    wr(`ECL_OFS_CMP, 32'h3); m_cmp = 3;
    cmd(`ECL_CMD_START); mstart(); chk_all();
    pb(3, 0, $urandom_range(8, 3)); chk_all();
    wr(`ECL_OFS_CMP, 32'h5); m_cmp = 5;
    pb(2, 0, $urandom_range(8, 3)); chk_all();
    wr(`ECL_OFS_CMP, 32'h7); m_cmp = 7;
    pb(2, 0, $urandom_range(8, 3)); chk_all();
    pb(2, 0, 4); chk_all();
    cmd(`ECL_CMD_SRST); m_mat = 0; m_ovr = 0; chk_all();
    cmd(`ECL_CMD_CRST); mreset(); chk_all();
    for (int w = 1; w >= 0; w--) begin
      wr(`ECL_OFS_LDATA, 32'h2); wr(`ECL_OFS_LDATA, 32'h4); wr(`ECL_OFS_LLEN, 32'h2);
      wr(`ECL_OFS_CTRL, 32'(w * 8 + 5));
      lst = '{2, 4}; m_len = 2; m_load = 1; m_wrap = w[0];
      cmd(`ECL_CMD_START); mstart();
      repeat (3) begin
        fork
          pb(2, 1, $urandom_range(8, 3));
          rd(`ECL_OFS_STAT);
        join
        chk_all();
        rd(`ECL_OFS_CMP);
        `CHK(rdat, 32'(m_cmp))
        cmd(`ECL_CMD_SRST); m_mat = 0; m_ovr = 0;
      end
      cmd(`ECL_CMD_STOP); m_run = 0;
      pb(2, 1, 4); chk_all();
      cmd(`ECL_CMD_CRST); mreset();
      rd(`ECL_OFS_CTRL);
      `CHK(rdat, 32'h0)
    end
    wr(`ECL_OFS_CTRL, 32'h2);
    cmd(`ECL_CMD_START); mstart();
    i_src.burst(1, 0, 10, 30);
    pb(1, 0, 30 + $urandom_range(10, 0)); chk_all();
    print_verdict();
  end
endmodule : event_counter_compare_load_tb_top
